/* shared/dac_serial_frame_port_consts.svh */
// Constants for the serial frame port of the multichannel converter
// What this block does
// - Serial data is taken into the input shift register on each of the first 24 falling serial clock edges after the strobe falls.
// - A falling frame strobe enables the clock and data input path and arms the shift register.
// - After the strobe falls, 24 falling clock edges each carry one bit of the frame.
// - A strobe that rises before the 24th falling edge aborts the frame and it is discarded.
// - The input shift register is exactly 24 bits wide.
// - In readback or chain mode the serial output is updated on each rising serial clock edge while the strobe is low.
// - While the reset input is low all state returns to its power-on values.
// - After reset returns high the port is ready for a new frame.
// - An unconnected reset input reads as high because of a weak pull-up.
// - Register commands choose whether each of the two dither inputs is added to the outputs.
`ifndef DAC_SERIAL_FRAME_PORT_CONSTS_SVH
`define DAC_SERIAL_FRAME_PORT_CONSTS_SVH

//------------------------------------------------------------
// Frame layout
//------------------------------------------------------------
`define FRAME_BITS 24
`define FRAME_MSB 23
`define CNT_W 5
`define CMD_MSB 23
`define CMD_LSB 20
`define DATA_MSB 15
`define DITHER_EN_BIT0 0
`define DITHER_EN_BIT1 1

//------------------------------------------------------------
// Command codes and reset values
//------------------------------------------------------------
`define CMD_DITHER 4'h8
`define CMD_READBACK 4'h9
`define CMD_CHAIN 4'hA
`define CMD_NORMAL 4'hB
`define FRAME_RST 24'h000000
`define DITHER_RST 2'h0

`endif

/* shared/dac_serial_frame_port_pkg.sv */
// Types for the serial frame port
package dac_serial_frame_port_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE = 2'b10
    } frame_state_t;

    typedef enum logic [1:0] {
        OUT_OFF = 2'b00,
        OUT_READBACK = 2'b01,
        OUT_CHAIN = 2'b10
    } out_mode_t;
endpackage

/* hdl/pin_sync.sv */
// Two-stage synchroniser with edge detection for one outside pin
`timescale 1ns/1ns
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Pin and results
    input wire logic pinIn,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_prev;

    // Next values of the synchroniser chain
    always_comb begin
        nxt_meta = pinIn;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    // Register chain
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= RESET_LEVEL;
            sync_ff <= RESET_LEVEL;
            prev_ff <= RESET_LEVEL;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // Edges from the second and third stages only
    assign level = sync_ff;
    assign rise = sync_ff & ~prev_ff;
    assign fall = ~sync_ff & prev_ff;
endmodule

/* hdl/dac_serial_frame_port.sv */
// Serial frame port: 24-bit shift in, abort detection, readback and chain output
`timescale 1ns/1ns
`include "dac_serial_frame_port_consts.svh"
module dac_serial_frame_port #(
    parameter int FRAME_BITS = `FRAME_BITS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Serial pins
    input wire logic frameSyncN,
    input wire logic serialClk,
    input wire logic serial_data_in,
    output logic serial_data_out,
    // Dither inputs
    input wire logic dither_input_0,
    input wire logic dither_input_1,
    // Results towards converter core
    output logic [FRAME_BITS-1:0] frameWord,
    output logic frameValid,
    output logic [1:0] ditherEnable,
    output logic [1:0] ditherActive,
    output logic frameAbort
);
    // Elaboration check: the frame layout is fixed at 24 bits
    if (FRAME_BITS != `FRAME_BITS) begin : g_bad_width
        $error("Frame width must be 24");
    end

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    logic syncLvl;
    logic syncRise;
    logic syncFall;
    logic sclkLvl;
    logic sclkRise;
    logic sclkFall;
    logic sdiLvl;
    logic d0Lvl;
    logic d1Lvl;

    // pull-up: strobe idles high, reset pin defaults high outside
    pin_sync #(.RESET_LEVEL(1'b1)) u_sync (
        .clk_sys(clk_sys), .rstn(rstn), .pinIn(frameSyncN),
        .level(syncLvl), .rise(syncRise), .fall(syncFall)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_sclk (
        .clk_sys(clk_sys), .rstn(rstn), .pinIn(serialClk),
        .level(sclkLvl), .rise(sclkRise), .fall(sclkFall)
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_sdi (
        .clk_sys(clk_sys), .rstn(rstn), .pinIn(serial_data_in),
        .level(sdiLvl), .rise(), .fall()
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_d0 (
        .clk_sys(clk_sys), .rstn(rstn), .pinIn(dither_input_0),
        .level(d0Lvl), .rise(), .fall()
    );
    pin_sync #(.RESET_LEVEL(1'b0)) u_d1 (
        .clk_sys(clk_sys), .rstn(rstn), .pinIn(dither_input_1),
        .level(d1Lvl), .rise(), .fall()
    );

    //------------------------------------------------------------
    // Frame state
    //------------------------------------------------------------
    dac_serial_frame_port_pkg::frame_state_t state_ff;
    dac_serial_frame_port_pkg::frame_state_t nxt_state;
    dac_serial_frame_port_pkg::out_mode_t mode_ff;
    dac_serial_frame_port_pkg::out_mode_t nxt_mode;
    logic [FRAME_BITS-1:0] shift_ff;
    logic [FRAME_BITS-1:0] nxt_shift;
    logic [FRAME_BITS-1:0] out_ff;
    logic [FRAME_BITS-1:0] nxt_out;
    logic [`CNT_W-1:0] cnt_ff;
    logic [`CNT_W-1:0] nxt_cnt;
    logic [FRAME_BITS-1:0] word_ff;
    logic [FRAME_BITS-1:0] nxt_word;
    logic valid_ff;
    logic nxt_valid;
    logic abort_ff;
    logic nxt_abort;
    logic [1:0] dith_ff;
    logic [1:0] nxt_dith;
    logic sdo_ff;
    logic nxt_sdo;

    // Command field of a finished frame
    function automatic logic [3:0] cmd_of(input logic [FRAME_BITS-1:0] w);
        cmd_of = w[`CMD_MSB:`CMD_LSB];
    endfunction

    // Next values of the frame engine
    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_shift = shift_ff;
        nxt_out = out_ff;
        nxt_cnt = cnt_ff;
        nxt_word = word_ff;
        nxt_valid = 1'b0;
        nxt_abort = 1'b0;
        nxt_dith = dith_ff;
        nxt_sdo = sdo_ff;
        case (state_ff)
            dac_serial_frame_port_pkg::ST_IDLE: begin
                if (syncFall) begin
                    nxt_state = dac_serial_frame_port_pkg::ST_SHIFT;
                    nxt_cnt = '0;
                    nxt_shift = `FRAME_RST;
                end
            end
            dac_serial_frame_port_pkg::ST_SHIFT: begin
                if (syncRise) begin
                    nxt_state = dac_serial_frame_port_pkg::ST_IDLE;
                    nxt_abort = 1'b1;
                end else if (sclkFall) begin
                    // one bit per falling edge, MSB first
                    nxt_shift = {shift_ff[FRAME_BITS-2:0], sdiLvl};
                    nxt_cnt = cnt_ff + `CNT_W'(1);
                    if (cnt_ff == `CNT_W'(`FRAME_BITS - 1)) begin
                        nxt_state = dac_serial_frame_port_pkg::ST_DONE;
                    end
                end else if (sclkRise && mode_ff != dac_serial_frame_port_pkg::OUT_OFF) begin
                    nxt_sdo = out_ff[`FRAME_MSB];
                    nxt_out = {out_ff[FRAME_BITS-2:0], 1'b0};
                end
            end
            dac_serial_frame_port_pkg::ST_DONE: begin
                // Frame acts only when the strobe closes it
                if (syncRise) begin
                    nxt_state = dac_serial_frame_port_pkg::ST_IDLE;
                    nxt_word = shift_ff;
                    nxt_valid = 1'b1;
                    // Chain mode passes the frame onward next time
                    nxt_out = shift_ff;
                    case (cmd_of(shift_ff))
                        `CMD_DITHER: begin
                            nxt_dith = {shift_ff[`DITHER_EN_BIT1], shift_ff[`DITHER_EN_BIT0]};
                        end
                        `CMD_READBACK: begin
                            nxt_mode = dac_serial_frame_port_pkg::OUT_READBACK;
                            nxt_out = word_ff;
                        end
                        `CMD_CHAIN: nxt_mode = dac_serial_frame_port_pkg::OUT_CHAIN;
                        `CMD_NORMAL: nxt_mode = dac_serial_frame_port_pkg::OUT_OFF;
                        default: ;
                    endcase
                end else if (sclkRise && mode_ff != dac_serial_frame_port_pkg::OUT_OFF) begin
                    nxt_sdo = out_ff[`FRAME_MSB];
                    nxt_out = {out_ff[FRAME_BITS-2:0], 1'b0};
                end
            end
            default: nxt_state = dac_serial_frame_port_pkg::ST_IDLE;
        endcase
        if (mode_ff == dac_serial_frame_port_pkg::OUT_OFF) begin
            nxt_sdo = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= dac_serial_frame_port_pkg::ST_IDLE;
            mode_ff <= dac_serial_frame_port_pkg::OUT_OFF;
            shift_ff <= `FRAME_RST;
            out_ff <= `FRAME_RST;
            cnt_ff <= '0;
            word_ff <= `FRAME_RST;
            valid_ff <= 1'b0;
            abort_ff <= 1'b0;
            dith_ff <= `DITHER_RST;
            sdo_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            shift_ff <= nxt_shift;
            out_ff <= nxt_out;
            cnt_ff <= nxt_cnt;
            word_ff <= nxt_word;
            valid_ff <= nxt_valid;
            abort_ff <= nxt_abort;
            dith_ff <= nxt_dith;
            sdo_ff <= nxt_sdo;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign serial_data_out = sdo_ff;
    assign frameWord = word_ff;
    assign frameValid = valid_ff;
    assign frameAbort = abort_ff;
    assign ditherEnable = dith_ff;
    assign ditherActive = dith_ff & {d1Lvl, d0Lvl};
    // Strobe level is otherwise unused beyond edge detection
    logic unusedLvl;
    assign unusedLvl = syncLvl ^ sclkLvl;
endmodule

/* test/dac_serial_frame_port_assertions.sv */
// Concurrent checks on the serial frame port
`timescale 1ns/1ns
module dac_serial_frame_port_assertions #(
    parameter int FRAME_BITS = 24
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Watched ports
    input wire logic frameSyncN,
    input wire logic serialClk,
    input wire logic dither_input_0,
    input wire logic [FRAME_BITS-1:0] frameWord,
    input wire logic frameValid,
    input wire logic [1:0] ditherEnable,
    input wire logic [1:0] ditherActive,
    input wire logic frameAbort
);
    logic [4:0] falls_ff, nxt_falls;
    logic sclk_ff, sync_ff;
    // Counts serial clock falls since the strobe fell
    always_comb begin
        nxt_falls = falls_ff;
        if (!frameSyncN && sync_ff) nxt_falls = 5'h0;
        else if (!frameSyncN && sclk_ff && !serialClk) nxt_falls = falls_ff + 5'h1;
    end
    // Registers the helper state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            falls_ff <= 5'h0;
            sclk_ff <= 1'b0;
            sync_ff <= 1'b1;
        end else begin
            falls_ff <= nxt_falls;
            sclk_ff <= serialClk;
            sync_ff <= frameSyncN;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence ditherOn;
        (ditherEnable[0] && dither_input_0) [*5];
    endsequence
    sequence quietAfter;
        (!frameValid && !frameAbort) [*3];
    endsequence
    full_frame_a: assert property (frameValid |-> falls_ff >= 5'h18)
        else $error("frame accepted without 24 falls");
    short_abort_a: assert property (frameAbort |-> falls_ff < 5'h18)
        else $error("abort after a full frame");
    valid_pulse_a: assert property (frameValid |=> !frameValid && !frameAbort)
        else $error("accept pulse too long");
    abort_pulse_a: assert property (frameAbort |=> !frameAbort && !frameValid)
        else $error("abort pulse too long");
    commit_high_a: assert property ((frameValid || frameAbort) |-> frameSyncN && $past(frameSyncN))
        else $error("result while strobe low");
    word_kept_a: assert property ($changed(frameWord) |-> (frameValid || $past(frameValid)) or ##1 frameValid)
        else $error("frame word moved without accept");
    dither_gate_a: assert property ((ditherActive & ~ditherEnable) == 2'h0)
        else $error("dither active while disabled");
    dither_on_a: assert property (ditherOn |-> ditherActive[0])
        else $error("enabled dither not active");
    reset_clear_a: assert property (disable iff (1'b0) !rstn |-> !(|frameWord) && ditherEnable == 2'h0 && !frameValid)
        else $error("state not cleared in reset");
    reset_quiet_a: assert property ($rose(rstn) |-> quietAfter)
        else $error("pulse right after reset");
endmodule
bind dac_serial_frame_port dac_serial_frame_port_assertions #(.FRAME_BITS(FRAME_BITS)) chk_i (
    .clk_sys(clk_sys), .rstn(rstn), .frameSyncN(frameSyncN), .serialClk(serialClk),
    .dither_input_0(dither_input_0), .frameWord(frameWord), .frameValid(frameValid),
    .ditherEnable(ditherEnable), .ditherActive(ditherActive), .frameAbort(frameAbort));

/* test/serial_host_model.sv */
// Behavioural serial host that frames, clocks and samples the port
`timescale 1ns/1ns
module serial_host_model (
    // Clock
    input wire logic clk_sys,
    // Serial pins
    output logic frameSyncN,
    output logic serialClk,
    output logic serialDataIn,
    input wire logic serialDataOut
);
    logic [23:0] rxWord = 24'h0;
    initial begin
        frameSyncN = 1'b1;
        serialClk = 1'b0;
        serialDataIn = 1'b0;
    end
    // half period hp of at least 13 cycles keeps the clock slow
    task automatic send(input logic [23:0] word, input int nBits, input int hp);
        @(posedge clk_sys);
        frameSyncN <= 1'b0;
        rxWord <= 24'h0;
        repeat (8) @(posedge clk_sys);
        // one bit per fall, bit 23 first
        for (int i = 0; i < nBits; i++) begin
            serialClk <= 1'b1;
            serialDataIn <= (i < 24) ? word[23 - i] : ~word[0];
            repeat (hp) @(posedge clk_sys);
            serialClk <= 1'b0;
            // output taken on the falling clock
            rxWord <= {rxWord[22:0], serialDataOut};
            repeat (hp) @(posedge clk_sys);
        end
        frameSyncN <= 1'b1;
        serialDataIn <= ~serialDataIn; // Released line loses its level
        repeat (24) @(posedge clk_sys);
    endtask
endmodule

/* test/tb.sv */
// Testbench for the serial frame port
`timescale 1ns/1ns
module tb;
    logic clk_sys, rstn, frameSyncN, serialClk, serialDataIn, serial_data_out;
    logic din0, din1, frameValid, frameAbort, rbMode;
    logic [23:0] frameWord, lastWord, w, expOut;
    logic [1:0] ditherEnable, ditherActive, expEn;
    int num_errors = 0, check_count = 0, seed = 32'hDE45, validCnt = 0, abortCnt = 0;
    int cycles = 0;
    logic [3:0] cmds [5] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h8};
    dac_serial_frame_port dac_serial_frame_port_i (.clk_sys(clk_sys), .rstn(rstn),
        .frameSyncN(frameSyncN), .serialClk(serialClk), .serial_data_in(serialDataIn),
        .serial_data_out(serial_data_out), .dither_input_0(din0), .dither_input_1(din1),
        .frameWord(frameWord), .frameValid(frameValid), .ditherEnable(ditherEnable),
        .ditherActive(ditherActive), .frameAbort(frameAbort));
    serial_host_model serial_host_model_i (.clk_sys(clk_sys), .frameSyncN(frameSyncN),
        .serialClk(serialClk), .serialDataIn(serialDataIn), .serialDataOut(serial_data_out));
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Counts result pulses and cuts a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (frameValid === 1'b1) validCnt <= validCnt + 1;
        if (frameAbort === 1'b1) abortCnt <= abortCnt + 1;
        if (cycles == 40000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // Sends a frame and compares the results with the bench model
    task automatic frame(input logic [23:0] word, input int nBits);
        int v = validCnt;
        int a = abortCnt;
        @(posedge clk_sys);
        din0 <= 1'($random(seed));
        din1 <= 1'($random(seed));
        serial_host_model_i.send(word, nBits, 13 + {$random(seed)} % 4);
        check(24'(validCnt - v), 24'((nBits >= 24) ? 1 : 0));
        check(24'(abortCnt - a), 24'((nBits < 24) ? 1 : 0));
        if (nBits >= 24) begin
            // Extra rises past the 24th push zeros out behind the word
            check(serial_host_model_i.rxWord, rbMode ? 24'(expOut << (nBits - 24)) : 24'h0);
            // Readback reloads the word accepted before it, others reload themselves
            if (word[23:20] == 4'h9) expOut = lastWord;
            else expOut = word;
            if (word[23:20] == 4'h8) expEn = word[1:0];
            if (word[23:20] == 4'h9 || word[23:20] == 4'hA) rbMode = 1'b1;
            if (word[23:20] == 4'hB) rbMode = 1'b0;
            lastWord = word;
        end else if (rbMode) begin
            // A cut frame still used up one output bit per rise
            expOut = 24'(expOut << nBits);
        end
        check(frameWord, lastWord);
        check({22'h0, ditherEnable}, {22'h0, expEn});
        check({22'h0, ditherActive}, {22'h0, expEn & {din1, din0}});
    endtask
    initial begin
        rstn <= 1'b0;
        din0 = 1'b0;
        din1 = 1'b0;
        lastWord = 24'h0;
        expOut = 24'h0;
        expEn = 2'h0;
        rbMode = 1'b0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int k = 0; k < 12; k++) begin
            w = 24'($random(seed));
            if (k < 5) w[23:20] = cmds[k];
            frame(w, 24);
        end
        frame(24'hA5A5A5, 0);
        frame(24'h8000F3, 23);
        frame(24'hFFFFFF, 24);
        frame(24'h800003, 26);
        frame(24'h000000, 24);
        frame(24'h900000, 24);
        frame(24'h123456, 24);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(frameWord, 24'h0);
        check({22'h0, ditherEnable}, 24'h0);
        rstn <= 1'b1;
        lastWord = 24'h0;
        expOut = 24'h0;
        expEn = 2'h0;
        rbMode = 1'b0;
        repeat (3) @(posedge clk_sys);
        frame(24'h800002, 24);
        tally_and_finish();
    end
endmodule
